/* verilog/adc_pkg.sv */
// Constants, codes and helpers of the converter control block
package adc_pkg;

  // Register offsets on the local port
  localparam logic [1:0] ADC_OFF_CTL0 = 2'h0;
  localparam logic [1:0] ADC_OFF_CTL1 = 2'h1;
  localparam logic [1:0] ADC_OFF_RES_HI = 2'h2;
  localparam logic [1:0] ADC_OFF_RES_LO = 2'h3;

  // Field positions, first control register
  localparam int ADC_C0_EN = 0;
  localparam int ADC_C0_GO = 1;
  localparam int ADC_C0_CHS = 2;
  // Field positions, second control register
  localparam int ADC_C1_PREF = 0;
  localparam int ADC_C1_NREF = 2;
  localparam int ADC_C1_CS = 4;
  localparam int ADC_C1_FM = 7;

  // Reset values of the control registers
  localparam logic [7:0] ADC_CTL0_RST = 8'h00;
  localparam logic [7:0] ADC_CTL1_RST = 8'h00;

  // Result width
  localparam int ADC_RES_W = 10;

  // Channel codes
  localparam logic [4:0] ADC_CH_LAST_EXT = 5'h0b;
  localparam logic [4:0] ADC_CH_TEMP = 5'h1d;
  localparam logic [4:0] ADC_CH_DAC = 5'h1e;
  localparam logic [4:0] ADC_CH_FVR = 5'h1f;

  // Clock select codes; RC matches on the low two bits
  localparam logic [2:0] ADC_CS_DIV2 = 3'h0;
  localparam logic [2:0] ADC_CS_DIV8 = 3'h1;
  localparam logic [2:0] ADC_CS_DIV32 = 3'h2;
  localparam logic [1:0] ADC_CS_RC_LOW = 2'h3;
  localparam logic [2:0] ADC_CS_DIV4 = 3'h4;
  localparam logic [2:0] ADC_CS_DIV16 = 3'h5;
  localparam logic [2:0] ADC_CS_DIV64 = 3'h6;

  // System clock divisors, in clk_sys cycles per step
  localparam logic [6:0] ADC_DIV2 = 7'h02;
  localparam logic [6:0] ADC_DIV4 = 7'h04;
  localparam logic [6:0] ADC_DIV8 = 7'h08;
  localparam logic [6:0] ADC_DIV16 = 7'h10;
  localparam logic [6:0] ADC_DIV32 = 7'h20;
  localparam logic [6:0] ADC_DIV64 = 7'h40;

  // Code to divisor
  function automatic logic [6:0] adc_div_of(input logic [2:0] sel);
    case (sel)
      ADC_CS_DIV2: adc_div_of = ADC_DIV2;
      ADC_CS_DIV8: adc_div_of = ADC_DIV8;
      ADC_CS_DIV32: adc_div_of = ADC_DIV32;
      ADC_CS_DIV4: adc_div_of = ADC_DIV4;
      ADC_CS_DIV16: adc_div_of = ADC_DIV16;
      ADC_CS_DIV64: adc_div_of = ADC_DIV64;
      default: adc_div_of = ADC_DIV2;
    endcase
  endfunction : adc_div_of

  // Does a channel code connect any source
  function automatic logic adc_chan_ok(input logic [4:0] channel_select);
    adc_chan_ok = (channel_select <= ADC_CH_LAST_EXT) ||
                  (channel_select >= ADC_CH_TEMP);
  endfunction : adc_chan_ok

  // High result byte in the chosen placement
  function automatic logic [7:0] adc_fmt_hi(input logic [9:0] r,
                                           input logic rj);
    adc_fmt_hi = rj ? {6'h00, r[9:8]} : r[9:2];
  endfunction : adc_fmt_hi

  // Low result byte in the chosen placement
  function automatic logic [7:0] adc_fmt_lo(input logic [9:0] r,
                                           input logic rj);
    adc_fmt_lo = rj ? r[7:0] : {r[1:0], 6'h00};
  endfunction : adc_fmt_lo

endpackage : adc_pkg

/* verilog/adc_tad_gen.sv */
// Conversion step enable generator: system divider or RC pulses
`timescale 1ns/1ps
module adc_tad_gen
  import adc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic rc_osc,
  output logic tad_q
);

  // Whole state of the generator
  typedef struct packed {
    logic rc_m; // First sync stage, read only by rc_s
    logic rc_s; // Second sync stage
    logic rc_p; // Delayed copy for edge detection
    logic [6:0] cnt; // Divider count
    logic tad; // One-cycle step enable
  } adc_tad_st_t;

  adc_tad_st_t s_q;
  adc_tad_st_t s_d;

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rc_m = rc_osc;
    s_d.rc_s = s_q.rc_m;
    s_d.rc_p = s_q.rc_s;
    s_d.tad = 1'b0;
    if (!run) begin
      // Idle converter restarts its step phase
      s_d.cnt = 7'h00;
    end else if (clk_sel[1:0] == ADC_CS_RC_LOW) begin
      // Rising edge of the RC oscillator is one step
      s_d.tad = s_q.rc_s && !s_q.rc_p;
    end else if (s_q.cnt + 7'h01 >= adc_div_of(clk_sel)) begin
      s_d.cnt = 7'h00;
      s_d.tad = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tad_q = s_q.tad;

  // Divide by two gives a step every other cycle
  property p_div2_spacing;
    @(posedge clk_sys) disable iff (rst)
      (tad_q && run && $past(run) && clk_sel == ADC_CS_DIV2 &&
       $stable(clk_sel)) |=> !tad_q ##1 (tad_q || !run ||
       clk_sel != ADC_CS_DIV2);
  endproperty
  a_div2_spacing: assert property (p_div2_spacing)
    else $error("divide by two spacing wrong");

  // No steps without a running conversion
  property p_no_step_idle;
    @(posedge clk_sys) disable iff (rst)
      !$past(run) |-> !tad_q;
  endproperty
  a_no_step_idle: assert property (p_no_step_idle)
    else $error("step pulse while idle");

endmodule : adc_tad_gen

/* verilog/adc_ctl.sv */
// Converter control and status registers with the SAR sequencer
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module adc_ctl
  import adc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata_q,
  input wire logic cmp_in,
  input wire logic rc_osc,
  output logic conv_enable_q,
  output logic conv_busy_q,
  output logic [4:0] chan_sel_q,
  output logic chan_valid_q,
  output logic [9:0] sar_code_q,
  output logic done_pulse_q,
  output logic nref_sel_q,
  output logic [1:0] pref_sel_q
);

  // Sequencer states
  typedef enum logic [0:0] {
    ADC_IDLE,
    ADC_CONV
  } adc_state_t;

  // Whole state of the block
  typedef struct packed {
    adc_state_t st; // Sequencer state
    logic [4:0] channel_select; // Channel select
    logic en; // Converter enable
    logic fm; // Result justification, 1 = right
    logic [2:0] cs; // Conversion clock select
    logic nref; // Negative reference select
    logic [1:0] pref; // Positive reference select
    logic [7:0] res_hi; // High result byte
    logic [7:0] res_lo; // Low result byte
    logic [9:0] sar; // Trial code to the analog core
    logic [3:0] idx; // Bit being decided
    logic last; // Last decided bit value
    logic cmp_m; // Comparator sync, first stage
    logic cmp_s; // Comparator sync, second stage
    logic [7:0] rdata; // Read data, valid one cycle
    logic done; // Completion pulse
    logic cv; // Channel connects a source
  } adc_st_t;

  adc_st_t s_q;
  adc_st_t s_d;
  logic tad;
  logic [9:0] fill_v; // Partial result after abort
  logic [9:0] step_v; // Code with current bit decided

  // Step enable for the successive approximation
  adc_tad_gen u_tad (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(s_q.st == ADC_CONV),
    .clk_sel(s_q.cs),
    .rc_osc(rc_osc),
    .tad_q(tad)
  );

  // Undecided bits copy the last decided one
  always_comb begin
    fill_v = s_q.sar;
    for (int i = 0; i < ADC_RES_W; i++) begin
      if (i <= int'(s_q.idx)) begin
        fill_v[i] = s_q.last;
      end
    end
  end

  // Current trial bit kept or dropped by the comparator
  always_comb begin
    step_v = s_q.sar;
    step_v[s_q.idx] = s_q.cmp_s;
  end

  // Next state: bus, sequencer, result loading
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rdata = 8'h00;
    // Comparator crosses from the analog domain
    s_d.cmp_m = cmp_in;
    s_d.cmp_s = s_q.cmp_m;

    // Successive approximation steps
    if (s_q.st == ADC_CONV && tad) begin
      s_d.last = s_q.cmp_s;
      if (s_q.idx == 4'h0) begin
        // Completion: status clears, flag, results load
        s_d.st = ADC_IDLE;
        s_d.done = 1'b1;
        s_d.sar = step_v;
        s_d.res_hi = adc_fmt_hi(step_v, s_q.fm);
        s_d.res_lo = adc_fmt_lo(step_v, s_q.fm);
      end else begin
        s_d.sar = step_v;
        s_d.sar[s_q.idx - 4'h1] = 1'b1;
        s_d.idx = s_q.idx - 4'h1;
      end
    end

    // Register writes; a start write wins over completion
    if (wr_en) begin
      case (addr)
        ADC_OFF_CTL0: begin
          s_d.channel_select = wdata[ADC_C0_CHS +: 5];
          s_d.en = wdata[ADC_C0_EN];
          if (!wdata[ADC_C0_EN]) begin
            // Turning off drops any conversion not completing this cycle, no update
            s_d.st = ADC_IDLE;
          end else if (wdata[ADC_C0_GO] && s_d.st == ADC_IDLE) begin
            // Also taken in the completing cycle: the start wins
            s_d.st = ADC_CONV;
            s_d.sar = 10'h200;
            s_d.idx = 4'h9;
            s_d.last = 1'b0;
          end else if (!wdata[ADC_C0_GO] && s_d.st == ADC_CONV) begin
            // Abort keeps what was converted so far
            s_d.st = ADC_IDLE;
            s_d.res_hi = adc_fmt_hi(fill_v, s_q.fm);
            s_d.res_lo = adc_fmt_lo(fill_v, s_q.fm);
          end
        end
        ADC_OFF_CTL1: begin
          s_d.fm = wdata[ADC_C1_FM];
          s_d.cs = wdata[ADC_C1_CS +: 3];
          s_d.nref = wdata[ADC_C1_NREF];
          s_d.pref = wdata[ADC_C1_PREF +: 2];
        end
        ADC_OFF_RES_HI: begin
          s_d.res_hi = wdata;
        end
        default: begin
          s_d.res_lo = wdata;
        end
      endcase
    end

    // Reads; unused bits come back as zero
    if (rd_en) begin
      case (addr)
        ADC_OFF_CTL0: begin
          s_d.rdata = {1'b0, s_q.channel_select,
                       s_q.st == ADC_CONV, s_q.en};
        end
        ADC_OFF_CTL1: begin
          s_d.rdata = {s_q.fm, s_q.cs, 1'b0,
                       s_q.nref, s_q.pref};
        end
        ADC_OFF_RES_HI: begin
          s_d.rdata = s_q.res_hi;
        end
        default: begin
          s_d.rdata = s_q.res_lo;
        end
      endcase
    end

    // Channel routing follows the next channel code
    s_d.cv = adc_chan_ok(s_d.channel_select);
  end

  // State register; results survive reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.channel_select <= ADC_CTL0_RST[ADC_C0_CHS +: 5];
      s_q.en <= ADC_CTL0_RST[ADC_C0_EN];
      s_q.fm <= ADC_CTL1_RST[ADC_C1_FM];
      s_q.cs <= ADC_CTL1_RST[ADC_C1_CS +: 3];
      s_q.nref <= ADC_CTL1_RST[ADC_C1_NREF];
      s_q.pref <= ADC_CTL1_RST[ADC_C1_PREF +: 2];
      s_q.cv <= 1'b1;
      s_q.res_hi <= s_q.res_hi;
      s_q.res_lo <= s_q.res_lo;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign rdata_q = s_q.rdata;
  assign conv_enable_q = s_q.en;
  assign conv_busy_q = s_q.st == ADC_CONV;
  assign chan_sel_q = s_q.channel_select;
  assign chan_valid_q = s_q.cv;
  assign sar_code_q = s_q.sar;
  assign done_pulse_q = s_q.done;
  assign nref_sel_q = s_q.nref;
  assign pref_sel_q = s_q.pref;

  // Steps of a start and its completion
  sequence s_start;
    wr_en && addr == ADC_OFF_CTL0 && wdata[ADC_C0_GO] &&
    wdata[ADC_C0_EN] && !conv_busy_q;
  endsequence

  // A start written in the last step restarts at once
  sequence s_finish;
    done_pulse_q && (!conv_busy_q || $past(wr_en));
  endsequence

  property p_unused_zero0;
    @(posedge clk_sys) disable iff (rst)
      rd_en && addr == ADC_OFF_CTL0 |=> !rdata_q[7];
  endproperty
  a_unused_zero0: assert property (p_unused_zero0)
    else $error("control zero bit 7 not zero");

  property p_unused_zero1;
    @(posedge clk_sys) disable iff (rst)
      rd_en && addr == ADC_OFF_CTL1 |=> !rdata_q[3];
  endproperty
  a_unused_zero1: assert property (p_unused_zero1)
    else $error("control one bit 3 not zero");

  property p_start;
    @(posedge clk_sys) disable iff (rst)
      s_start |=> conv_busy_q ##1 (conv_busy_q || !conv_enable_q ||
      $past(wr_en));
  endproperty
  a_start: assert property (p_start)
    else $error("start write did not begin conversion");

  property p_busy_reads_one;
    @(posedge clk_sys) disable iff (rst)
      rd_en && addr == ADC_OFF_CTL0 |=>
      rdata_q[ADC_C0_GO] == $past(conv_busy_q);
  endproperty
  a_busy_reads_one: assert property (p_busy_reads_one)
    else $error("status bit does not follow conversion");

  property p_finish;
    @(posedge clk_sys) disable iff (rst)
      done_pulse_q |-> s_finish and $past(conv_busy_q);
  endproperty
  a_finish: assert property (p_finish)
    else $error("done pulse without end of conversion");

  property p_left_load;
    @(posedge clk_sys) disable iff (rst)
      done_pulse_q && !$past(wr_en) && !s_q.fm |->
      s_q.res_hi == sar_code_q[9:2] &&
      s_q.res_lo == {sar_code_q[1:0], 6'h00};
  endproperty
  a_left_load: assert property (p_left_load)
    else $error("left justified result misplaced");

  property p_right_load;
    @(posedge clk_sys) disable iff (rst)
      done_pulse_q && !$past(wr_en) && s_q.fm |->
      s_q.res_lo == sar_code_q[7:0] && s_q.res_hi[7:2] == 6'h00;
  endproperty
  a_right_load: assert property (p_right_load)
    else $error("right justified result misplaced");

  property p_off_idle;
    @(posedge clk_sys) disable iff (rst)
      !conv_enable_q |-> !conv_busy_q;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("conversion running while disabled");

  property p_abort;
    @(posedge clk_sys) disable iff (rst)
      wr_en && addr == ADC_OFF_CTL0 && !wdata[ADC_C0_GO] &&
      conv_busy_q && !(tad && s_q.idx == 4'h0) |=>
      !conv_busy_q && !done_pulse_q;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not stop conversion");

  property p_reserved_chan;
    @(posedge clk_sys) disable iff (rst)
      chan_sel_q > ADC_CH_LAST_EXT && chan_sel_q < ADC_CH_TEMP
      |-> !chan_valid_q;
  endproperty
  a_reserved_chan: assert property (p_reserved_chan)
    else $error("reserved channel connected");

  property p_valid_chan;
    @(posedge clk_sys) disable iff (rst)
      chan_sel_q <= ADC_CH_LAST_EXT || chan_sel_q >= ADC_CH_TEMP
      |-> chan_valid_q;
  endproperty
  a_valid_chan: assert property (p_valid_chan)
    else $error("valid channel not connected");

  property p_reset_zero;
    @(posedge clk_sys) rst |=> !conv_enable_q && !conv_busy_q &&
      chan_sel_q == 5'h00 && pref_sel_q == 2'h0 && !nref_sel_q;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("controls not cleared by reset");

endmodule : adc_ctl

/* testbench/testbench.sv */
// Self-checking bench of the converter control registers
`timescale 1ns/1ps
module testbench
  import adc_pkg::*;
;
  logic clk_sys = 1'b0; // System clock
  logic rst = 1'b1; // Synchronous reset
  logic [1:0] addr = 2'h0; // Register offset
  logic [7:0] wdata = 8'h00; // Write data
  logic wr_en = 1'b0; // Write strobe
  logic rd_en = 1'b0; // Read strobe
  logic cmp_in = 1'b0; // Comparator, held steady per conversion
  logic rc_osc = 1'b0; // RC source, still outside conversions
  logic [7:0] rdata_q; // Read data
  logic conv_enable_q; // Enable level
  logic conv_busy_q; // Status level
  logic chan_valid_q; // Channel connects a source
  logic done_pulse_q; // Completion event
  logic nref_sel_q; // Negative reference
  logic [1:0] pref_sel_q; // Positive reference
  logic [4:0] chan_sel_q; // Channel code
  logic [9:0] sar_code_q; // Trial code, final result after completion
  int num_errors = 0; // Mismatches
  int n_checks = 0; // Comparisons

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  adc_ctl i_adc_ctl (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .cmp_in(cmp_in),
    .rc_osc(rc_osc), .conv_enable_q(conv_enable_q),
    .conv_busy_q(conv_busy_q), .chan_sel_q(chan_sel_q),
    .chan_valid_q(chan_valid_q), .sar_code_q(sar_code_q),
    .done_pulse_q(done_pulse_q), .nref_sel_q(nref_sel_q),
    .pref_sel_q(pref_sel_q)
  );

  // Counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Four-state compare; an unknown matches only an unknown
  task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  // Read, data taken in the following cycle only
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rdata_q;
  endtask : rd

  // Read and compare
  task automatic rchk(input logic [1:0] a, input logic [7:0] e,
                      input string what);
    logic [7:0] d;
    rd(a, d);
    chk(10'(d), 10'(e), what);
  endtask : rchk

  // Bounded wait for the completion event; a hang ends the run
  task automatic wait_done(input int lim, output int n);
    n = 0;
    while (done_pulse_q !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (done_pulse_q !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: no completion", $time);
      give_verdict();
    end
  endtask : wait_done

  // No completion event for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      chk(10'(done_pulse_q), 10'h0, "stray completion");
    end
  endtask : quiet

  // Values right after the first reset
  task automatic t_reset();
    #1;
    chk(10'(conv_busy_q), 10'h0, "busy at reset");
    chk(10'(conv_enable_q), 10'h0, "enable at reset");
    rchk(ADC_OFF_CTL0, 8'h00, "ctl0 reset");
    rchk(ADC_OFF_CTL1, 8'h00, "ctl1 reset");
    $display("test reset finished");
  endtask : t_reset

  // Unused bits read zero, fields reach the outputs
  task automatic t_fields();
    wr(ADC_OFF_CTL0, 8'hfd);
    rchk(ADC_OFF_CTL0, 8'h7d, "ctl0 readback");
    chk(10'(chan_sel_q), 10'h1f, "channel out");
    chk(10'(conv_enable_q), 10'h1, "enable out");
    wr(ADC_OFF_CTL1, 8'hff);
    rchk(ADC_OFF_CTL1, 8'hf7, "ctl1 readback");
    chk(10'({nref_sel_q, pref_sel_q}), 10'h7, "references");
    $display("test fields finished");
  endtask : t_fields

  // Every channel code: external, reserved, internal
  task automatic t_channels();
    for (int c = 0; c < 32; c++) begin
      wr(ADC_OFF_CTL0, {1'b0, 5'(c), 2'h1});
      repeat (2) @(posedge clk_sys);
      #1;
      chk(10'(chan_valid_q), 10'(c <= 11 || c >= 29), "valid");
    end
    $display("test channels finished");
  endtask : t_channels

  // Conversion length per system divider clock select code
  task automatic t_divisors();
    logic [2:0] code [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    int n;
    int lo;
    for (int i = 0; i < 6; i++) begin
      lo = 10 << (i + 1);
      wr(ADC_OFF_CTL1, {1'b0, code[i], 4'h0});
      cmp_in <= 1'b1;
      wr(ADC_OFF_CTL0, 8'h03);
      wait_done(800, n);
      chk(10'(n >= lo && n <= lo + 4), 10'h1, "step rate");
    end
    $display("test divisors finished");
  endtask : t_divisors

  // Status during and after a run, both placements
  task automatic t_results();
    int n;
    for (int i = 0; i < 2; i++) begin
      wr(ADC_OFF_CTL1, {i[0], 7'h00});
      cmp_in <= i[0];
      wr(ADC_OFF_CTL0, 8'h03);
      rchk(ADC_OFF_CTL0, 8'h03, "status running");
      wait_done(100, n);
      chk(10'(conv_busy_q), 10'h0, "busy at done");
      chk(sar_code_q, i ? 10'h3ff : 10'h000, "final code");
      rchk(ADC_OFF_CTL0, 8'h01, "status idle");
      rchk(ADC_OFF_RES_HI, i ? 8'h03 : 8'h00, "high");
      rchk(ADC_OFF_RES_LO, i ? 8'hff : 8'h00, "low");
    end
    $display("test results finished");
  endtask : t_results

  // Abort after a few decided ones: fill with the last bit
  task automatic t_abort();
    wr(ADC_OFF_CTL1, 8'h60);
    cmp_in <= 1'b1;
    wr(ADC_OFF_RES_HI, 8'h00);
    wr(ADC_OFF_RES_LO, 8'h00);
    rchk(ADC_OFF_RES_HI, 8'h00, "result writable");
    wr(ADC_OFF_CTL0, 8'h03);
    repeat (200) @(posedge clk_sys);
    wr(ADC_OFF_CTL0, 8'h01);
    quiet(60);
    chk(10'(conv_busy_q), 10'h0, "busy after abort");
    rchk(ADC_OFF_RES_HI, 8'hff, "partial high");
    rchk(ADC_OFF_RES_LO, 8'hc0, "partial low");
    $display("test abort finished");
  endtask : t_abort

  // RC source: no progress until its edges arrive
  task automatic t_rc();
    int k;
    wr(ADC_OFF_CTL1, 8'h30);
    wr(ADC_OFF_CTL0, 8'h03);
    repeat (100) @(posedge clk_sys);
    #1;
    chk(10'(conv_busy_q), 10'h1, "rc stalled");
    chk(sar_code_q, 10'h200, "rc first trial");
    for (k = 0; k < 400 && done_pulse_q !== 1'b1; k++) begin
      @(posedge clk_sys);
      rc_osc <= k[1];
      #1;
    end
    chk(10'(done_pulse_q), 10'h1, "rc completion");
    // A run out of steps ends the run here
    if (done_pulse_q !== 1'b1) begin
      give_verdict();
    end
    @(posedge clk_sys);
    rc_osc <= 1'b0;
    rchk(ADC_OFF_RES_HI, 8'hff, "rc result");
    $display("test rc finished");
  endtask : t_rc

  // Clearing enable ends a run; start needs enable
  task automatic t_disable();
    wr(ADC_OFF_CTL1, 8'h00);
    wr(ADC_OFF_CTL0, 8'h03);
    repeat (4) @(posedge clk_sys);
    wr(ADC_OFF_CTL0, 8'h00);
    quiet(40);
    chk(10'(conv_busy_q), 10'h0, "busy off");
    chk(10'(conv_enable_q), 10'h0, "enable off");
    wr(ADC_OFF_CTL0, 8'h02);
    quiet(4);
    rchk(ADC_OFF_CTL0, 8'h00, "no start");
    $display("test disable finished");
  endtask : t_disable

  // Reset with controls set but no run started: controls clear, results kept
  task automatic t_rereset();
    wr(ADC_OFF_CTL1, 8'hb7);
    wr(ADC_OFF_CTL0, 8'h7d);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(10'(conv_enable_q), 10'h0, "enable cleared");
    rchk(ADC_OFF_CTL0, 8'h00, "ctl0 cleared");
    rchk(ADC_OFF_CTL1, 8'h00, "ctl1 cleared");
    rchk(ADC_OFF_RES_HI, 8'hff, "high kept");
    rchk(ADC_OFF_RES_LO, 8'hc0, "low kept");
    $display("test rereset finished");
  endtask : t_rereset

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_channels();
    t_divisors();
    t_results();
    t_abort();
    t_rc();
    t_disable();
    t_rereset();
    give_verdict();
  end
endmodule : testbench
